//--- logic/panel_ctrl_defines.vh
// Constants for the panel control output selection block
`ifndef PANEL_CTRL_DEFINES_VH
`define PANEL_CTRL_DEFINES_VH
`define LINE_LEN 10'd400
`define GATE_CLK_HALF 10'd200
`define STB_WIDTH 10'd4
`define OE_A_START 10'd20
`define OE_A_END 10'd180
`define OE_B_START 10'd220
`define OE_B_END 10'd380
`define MUX_SLOT 10'd120
`define FRAME_LINES 10'd320
`define AUX_PERIOD_LINES 10'd1
`define ROLE_SLAVE 1'b0
`define ROLE_MASTER 1'b1
`define STRAP_GEN 1'b0
`define STRAP_BYPASS 1'b1
`endif

//--- logic/panel_timing_gen.v
// Internal timing generator for gate, mux and aux panel signals
`timescale 1ns/1ps
`default_nettype none
`include "panel_ctrl_defines.vh"
module panel_timing_gen #(
    parameter LINE_LEN = `LINE_LEN,
    parameter FRAME_LINES = `FRAME_LINES
) (
    input wire clk_i,
    input wire nrst_i,
    input wire enable_i,
    input wire is_master_i,
    input wire ext_line_start_i,
    output reg gate_shift_clock_out,
    output reg gate_strobe_out,
    output reg goe_a_o,
    output reg goe_b_o,
    output reg red_o,
    output reg green_o,
    output reg blue_o,
    output reg [2:0] aux_o,
    output wire line_start_o
);
    reg [9:0] pix_reg;
    reg [9:0] line_reg;
    wire line_end;
    wire [9:0] line_len_w;
    wire [9:0] frame_w;

    assign line_len_w = LINE_LEN[9:0];
    assign frame_w = FRAME_LINES[9:0];
    assign line_end = (pix_reg == line_len_w - 10'd1);
    assign line_start_o = enable_i & (pix_reg == 10'h000);

    ////////////////////////////////////////////////////////////////////
    // Pixel and line counters; slave follows master line start
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pix_reg <= 10'h000;
            line_reg <= 10'h000;
        end else if (!enable_i) begin
            pix_reg <= 10'h000;
            line_reg <= 10'h000;
        end else if (!is_master_i && ext_line_start_i) begin
            pix_reg <= 10'h001;
        end else if (line_end) begin
            pix_reg <= 10'h000;
            if (line_reg == frame_w - 10'd1) begin
                line_reg <= 10'h000;
            end else begin
                line_reg <= line_reg + 10'd1;
            end
        end else begin
            pix_reg <= pix_reg + 10'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered waveforms decoded from the counters
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_shift_clock_out <= 1'b0;
            gate_strobe_out <= 1'b0;
            goe_a_o <= 1'b0;
            goe_b_o <= 1'b0;
            red_o <= 1'b0;
            green_o <= 1'b0;
            blue_o <= 1'b0;
            aux_o <= 3'h0;
        end else begin
            gate_shift_clock_out <= enable_i & (pix_reg >= `GATE_CLK_HALF);
            gate_strobe_out <= enable_i & (line_reg == 10'h000) &
                (pix_reg < `STB_WIDTH);
            goe_a_o <= enable_i & (pix_reg >= `OE_A_START) &
                (pix_reg < `OE_A_END);
            goe_b_o <= enable_i & (pix_reg >= `OE_B_START) &
                (pix_reg < `OE_B_END);
            red_o <= enable_i & (pix_reg < `MUX_SLOT);
            green_o <= enable_i & (pix_reg >= `MUX_SLOT) &
                (pix_reg < (`MUX_SLOT + `MUX_SLOT));
            blue_o <= enable_i & (pix_reg >= (`MUX_SLOT + `MUX_SLOT)) &
                (pix_reg < (`MUX_SLOT + `MUX_SLOT + `MUX_SLOT));
            aux_o <= enable_i ? {line_reg[0], ~line_reg[0], 1'b1} : 3'h0;
        end
    end
endmodule // panel_timing_gen
`default_nettype wire

//--- logic/panel_control_output_select.v
// Top: selects panel control outputs from generator or external pins
`timescale 1ns/1ps
`default_nettype none
`include "panel_ctrl_defines.vh"
module panel_control_output_select #(
    parameter LINE_LEN = `LINE_LEN,
    parameter FRAME_LINES = `FRAME_LINES,
    parameter SCAN_RIGHT = 1'b1
) (
    input wire clk_i,
    input wire nrst_i,
    input wire timing_gen_bypass_strap_i,
    input wire cascade_role_select_i,
    input wire line_sync_in_i,
    input wire gate_shift_clock_in_i,
    input wire gate_strobe_in_i,
    input wire gate_out_enable_a_in_i,
    input wire gate_out_enable_b_in_i,
    input wire red_mux_switch_in_i,
    input wire green_mux_switch_in_i,
    input wire blue_mux_switch_in_i,
    input wire panel_aux_ctrl_a_in_i,
    input wire panel_aux_ctrl_b_in_i,
    input wire panel_aux_ctrl_c_in_i,
    output wire gate_shift_clock_out_o,
    output wire gate_strobe_out_o,
    output wire gate_out_enable_a_out_o,
    output wire gate_out_enable_b_out_o,
    output wire gate_scan_direction_out_o,
    output wire red_mux_switch_out_o,
    output wire green_mux_switch_out_o,
    output wire blue_mux_switch_out_o,
    output wire panel_aux_ctrl_a_out_o,
    output wire panel_aux_ctrl_b_out_o,
    output wire panel_aux_ctrl_c_out_o,
    output wire is_master_o,
    output wire line_sync_out_o
);
    // Number of switched control lines
    localparam NUM_CTRL = 10;

    wire bypass;
    wire gen_en;
    wire is_master;
    wire g_clk, g_stb, g_oea, g_oeb, g_r, g_g, g_b;
    wire [2:0] g_aux;
    wire line_start;
    wire [NUM_CTRL-1:0] ext_vec;
    wire [NUM_CTRL-1:0] gen_vec;
    wire [NUM_CTRL-1:0] sel_vec;

    ////////////////////////////////////////////////////////////////////
    // Mode decode from the straps
    assign bypass = (timing_gen_bypass_strap_i == `STRAP_BYPASS);
    assign gen_en = ~bypass;
    assign is_master = (cascade_role_select_i == `ROLE_MASTER);
    assign is_master_o = gen_en & is_master;
    assign line_sync_out_o = is_master & line_start;

    ////////////////////////////////////////////////////////////////////
    // Internal generator, held idle and reset while bypassed
    panel_timing_gen #(
        .LINE_LEN(LINE_LEN),
        .FRAME_LINES(FRAME_LINES)
    ) u_gen (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .enable_i(gen_en),
        .is_master_i(is_master),
        .ext_line_start_i(line_sync_in_i),
        .gate_shift_clock_out(g_clk),
        .gate_strobe_out(g_stb),
        .goe_a_o(g_oea),
        .goe_b_o(g_oeb),
        .red_o(g_r),
        .green_o(g_g),
        .blue_o(g_b),
        .aux_o(g_aux),
        .line_start_o(line_start)
    );

    ////////////////////////////////////////////////////////////////////
    // Both sources in one bit order: gate clock, strobe, enables a
    // and b, red, green, blue, then aux a, b and c
    assign ext_vec = {panel_aux_ctrl_c_in_i, panel_aux_ctrl_b_in_i,
        panel_aux_ctrl_a_in_i, blue_mux_switch_in_i, green_mux_switch_in_i,
        red_mux_switch_in_i, gate_out_enable_b_in_i, gate_out_enable_a_in_i,
        gate_strobe_in_i, gate_shift_clock_in_i};
    assign gen_vec = {g_aux[2], g_aux[1], g_aux[0], g_b, g_g, g_r, g_oeb,
        g_oea, g_stb, g_clk};

    ////////////////////////////////////////////////////////////////////
    // One selector per line; bypass is a direct combinational path,
    // so the external source reaches the pin with no clock delay
    genvar k;
    generate
        for (k = 0; k < NUM_CTRL; k = k + 1) begin : g_sel
            assign sel_vec[k] = bypass ? ext_vec[k] : gen_vec[k];
        end
    endgenerate

    // Level-shifted outputs, same polarity as their sources
    assign gate_shift_clock_out_o = sel_vec[0];
    assign gate_strobe_out_o = sel_vec[1];
    assign gate_out_enable_a_out_o = sel_vec[2];
    assign gate_out_enable_b_out_o = sel_vec[3];
    assign red_mux_switch_out_o = sel_vec[4];
    assign green_mux_switch_out_o = sel_vec[5];
    assign blue_mux_switch_out_o = sel_vec[6];
    assign panel_aux_ctrl_a_out_o = sel_vec[7];
    assign panel_aux_ctrl_b_out_o = sel_vec[8];
    assign panel_aux_ctrl_c_out_o = sel_vec[9];

    // Fixed scan direction toward the gate circuit
    assign gate_scan_direction_out_o = SCAN_RIGHT[0];
endmodule // panel_control_output_select
`default_nettype wire

//--- dv/panel_ctrl_checker.sv
// Checker for the panel control output selection block
`timescale 1ns/1ps
`default_nettype none
module panel_ctrl_checker #(
    parameter LINE_LEN = 400,
    parameter FRAME_LINES = 320
) (
    input wire clk_i, nrst_i, timing_gen_bypass_strap_i, cascade_role_select_i,
    input wire gate_shift_clock_in_i, gate_shift_clock_out_o,
    input wire gate_strobe_in_i, gate_strobe_out_o,
    input wire gate_out_enable_a_in_i, gate_out_enable_a_out_o,
    input wire gate_out_enable_b_in_i, gate_out_enable_b_out_o,
    input wire red_mux_switch_in_i, red_mux_switch_out_o,
    input wire green_mux_switch_in_i, green_mux_switch_out_o,
    input wire blue_mux_switch_in_i, blue_mux_switch_out_o,
    input wire panel_aux_ctrl_a_in_i, panel_aux_ctrl_a_out_o,
    input wire panel_aux_ctrl_b_in_i, panel_aux_ctrl_b_out_o,
    input wire panel_aux_ctrl_c_in_i, panel_aux_ctrl_c_out_o,
    input wire gate_scan_direction_out_o, is_master_o, line_sync_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire b = timing_gen_bypass_strap_i;
    // Line start and the red then green mux slots after it
    sequence line_start;
        !b && line_sync_out_o;
    endsequence
    sequence red_then_green;
        red_mux_switch_out_o && !green_mux_switch_out_o ##120
        !red_mux_switch_out_o && green_mux_switch_out_o;
    endsequence
    AST_SEQ: assert property (line_start |=> red_then_green)
        else $error("mux slots");
    AST_GCLK: assert property (b |->
        gate_shift_clock_out_o == gate_shift_clock_in_i) else $error("gclk");
    AST_STB: assert property (b |->
        gate_strobe_out_o == gate_strobe_in_i) else $error("stb");
    AST_OE: assert property (b |-> {gate_out_enable_a_out_o,
        gate_out_enable_b_out_o} == {gate_out_enable_a_in_i,
        gate_out_enable_b_in_i}) else $error("oe");
    AST_RED: assert property (b |->
        red_mux_switch_out_o == red_mux_switch_in_i) else $error("red");
    AST_GRN: assert property (b |->
        green_mux_switch_out_o == green_mux_switch_in_i) else $error("grn");
    AST_BLU: assert property (b |->
        blue_mux_switch_out_o == blue_mux_switch_in_i) else $error("blu");
    AST_AUX: assert property (b |-> {panel_aux_ctrl_a_out_o,
        panel_aux_ctrl_b_out_o, panel_aux_ctrl_c_out_o} ==
        {panel_aux_ctrl_a_in_i, panel_aux_ctrl_b_in_i, panel_aux_ctrl_c_in_i})
        else $error("aux");
    AST_DIR: assert property ($stable(gate_scan_direction_out_o))
        else $error("dir");
    AST_MAS: assert property (is_master_o == (!b &&
        cascade_role_select_i)) else $error("role");
endmodule // panel_ctrl_checker
bind panel_control_output_select panel_ctrl_checker #(.LINE_LEN(LINE_LEN),
    .FRAME_LINES(FRAME_LINES)) u_chk (.*);
`default_nettype wire

//--- dv/gate_driver_model.sv
// Gate driver model: counts shift clocks since the last strobe
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
    input wire gate_shift_clock_in,
    input wire gate_strobe_in,
    output logic [7:0] rows_o
);
    // Row pointer restarts on strobe
    always @(posedge gate_shift_clock_in or posedge gate_strobe_in) begin
        if (gate_strobe_in) begin
            rows_o <= 8'h00;
        end else begin
            rows_o <= rows_o + 8'h01;
        end
    end
endmodule // gate_driver_model
`default_nettype wire

//--- dv/tb.sv
// Testbench for the panel control output selection block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0, nrst_i = 1'b0, strap = 1'b1, role = 1'b1;
    logic sync_i = 1'b0;
    logic [9:0] x = 10'h000;
    wire [9:0] y;
    wire dir, mas, sync_o;
    wire [7:0] rows;
    int err_count = 0, total_checks = 0, n;
    always #12.5 clk_i = ~clk_i;
    panel_control_output_select #(.FRAME_LINES(4)) dut (.clk_i(clk_i),
        .nrst_i(nrst_i), .timing_gen_bypass_strap_i(strap),
        .cascade_role_select_i(role), .line_sync_in_i(sync_i),
        .gate_shift_clock_in_i(x[0]), .gate_strobe_in_i(x[1]),
        .gate_out_enable_a_in_i(x[2]), .gate_out_enable_b_in_i(x[3]),
        .red_mux_switch_in_i(x[4]), .green_mux_switch_in_i(x[5]),
        .blue_mux_switch_in_i(x[6]), .panel_aux_ctrl_a_in_i(x[7]),
        .panel_aux_ctrl_b_in_i(x[8]), .panel_aux_ctrl_c_in_i(x[9]),
        .gate_shift_clock_out_o(y[0]), .gate_strobe_out_o(y[1]),
        .gate_out_enable_a_out_o(y[2]), .gate_out_enable_b_out_o(y[3]),
        .red_mux_switch_out_o(y[4]), .green_mux_switch_out_o(y[5]),
        .blue_mux_switch_out_o(y[6]), .panel_aux_ctrl_a_out_o(y[7]),
        .panel_aux_ctrl_b_out_o(y[8]), .panel_aux_ctrl_c_out_o(y[9]),
        .gate_scan_direction_out_o(dir), .is_master_o(mas),
        .line_sync_out_o(sync_o));
    gate_driver_model pm (.gate_shift_clock_in(y[0]), .gate_strobe_in(y[1]), .rows_o(rows));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_sync();
        n = 0;
        do begin @(negedge clk_i); n++; end while (sync_o !== 1'b1 && n < 500);
    endtask
    // Walking one and zero through every bypass path, role held high
    task automatic test_bypass();
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_i);
            x <= (i < 10) ? 10'h001 << i :
                ~(10'h001 << (i - 10));
            @(negedge clk_i);
            check(y, x);
        end
        check(y, x);
        check({mas, dir}, 2'h1);
    endtask
    // Strobe then five shift clocks seen by the gate driver
    task automatic test_partner();
        @(posedge clk_i);
        x <= 10'h002;
        @(posedge clk_i);
        x <= 10'h000;
        repeat (5) begin
            @(posedge clk_i);
            x <= 10'h001;
            @(posedge clk_i);
            x <= 10'h000;
        end
        @(negedge clk_i);
        check(rows, 5);
    endtask
    // Master generator: reset, first two lines, inputs ignored
    task automatic test_master();
        @(posedge clk_i);
        {nrst_i, strap, x} <= {2'h0, 10'h3FF};
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check(y, 0);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        wait_sync();
        @(negedge clk_i);
        check(y, 10'h192);
        check(mas, 1);
        wait_sync();
        check(16'(n + 1), 16'd400);
        @(negedge clk_i);
        check(y, 10'h290);
    endtask
    // Slave role emits no line sync and aligns its line to the input
    task automatic test_slave();
        @(posedge clk_i);
        role <= 1'b0;
        wait_sync();
        check({mas, n[14:0]}, 16'd500);
        @(posedge clk_i);
        sync_i <= 1'b1;
        @(posedge clk_i);
        sync_i <= 1'b0;
        repeat (119) @(posedge clk_i);
        @(negedge clk_i);
        check(y[6:4], 3'h1);
        @(negedge clk_i);
        check(y[6:4], 3'h2);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        test_bypass();
        test_partner();
        test_master();
        test_slave();
        stop_test();
    end
    // Watchdog
    initial begin
        #200us;
        err_count++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
